// ### emb_mem_model.sv
// external program, data and boot memories on the shared pins
// assumes selects and strobes active low, gated by ctl_oe
module emb_mem_model (
	input wire logic mclk, // clock
	input wire logic [13:0] addr_out, // address pins
	input wire logic [23:0] d_out, // data driven by block
	input wire logic [23:0] d_oe, // data drive enables
	input wire logic prog_mem_select_n, // program select
	input wire logic data_mem_select_n, // data select
	input wire logic boot_mem_select_n, // boot select
	input wire logic rd_n, // read strobe
	input wire logic wr_n, // write strobe
	input wire logic ctl_oe, // select/strobe enable
	output logic [23:0] d_in // data seen by block
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] pm [16]; // program words, low address bits only
	logic [15:0] dm [16]; // data words
	logic [23:0] junk = 24'h5A3C96; // undriven bus, changes every cycle
	logic [1:0] pg; // upper boot address bits from the data bus
	////////////////////////////////////////
	// nothing holds a released bus, so it must not look stable
	always @(posedge mclk) begin
		junk <= {junk[22:0], ~junk[23]};
	end
	// page bits only count while the block drives them
	assign pg = (d_oe[23:22] === 2'b11) ? d_out[23:22] : junk[1:0];
	// asynchronous read path, enabled by select and read strobe
	always_comb begin
		d_in = junk;
		if (ctl_oe && !rd_n) begin
			if (!prog_mem_select_n) begin
				d_in = pm[addr_out[3:0]];
			end else if (!data_mem_select_n) begin
				d_in = {dm[addr_out[3:0]], junk[7:0]};
			end else if (!boot_mem_select_n) begin
				d_in = {junk[23:16],
					{pg, addr_out[13], addr_out[4:0]} ^ 8'h3C, junk[7:0]};
			end
		end
	end
	// writes land while the write strobe is low
	always @(posedge mclk) begin
		if (ctl_oe && !wr_n) begin
			if (!prog_mem_select_n) begin
				pm[addr_out[3:0]] <= d_out;
			end else if (!data_mem_select_n) begin
				dm[addr_out[3:0]] <= d_out[23:8];
			end
		end
	end
endmodule : emb_mem_model

// ### emb_params.svh
// named constants of the external memory bus interface
// assumes inclusion by bare name from each design file that needs them
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
// register addresses, inside the reserved data space
`define EMB_A_SYSCTL 14'h3FFF
`define EMB_A_DMWAIT 14'h3FFE
`define EMB_A_STATUS 14'h3FFD
`define EMB_A_LBX 14'h3FFC
// system control field positions (lsb of each field)
`define EMB_SC_PMWS 0
`define EMB_SC_BWS 3
`define EMB_SC_PAGE 6
`define EMB_SC_FORCE 9
`define EMB_SC_GO 10
// reset values
`define EMB_PM_WS_RST 3'h7
`define EMB_BOOT_WS_RST 3'h3
`define EMB_DM_WS_RST 15'h7FFF
`define EMB_PAGE_RST 3'h0
// memory map boundaries
`define EMB_PM_LO_END 14'h0800
`define EMB_PM_HI_BASE 14'h3800
`define EMB_DM_INT_BASE 14'h3800
// data zones: 2K blocks, last zone takes the rest
`define EMB_ZONE_LAST 3'h4
// drive masks for the shared data bus
`define EMB_BOOT_OE 24'hC00000
`define EMB_DM_OE 24'hFFFF00
`define EMB_PM_OE 24'hFFFFFF
// cycles spent after reset release before the map strap is used
`define EMB_START_CYC 3'h4
// boot image length in program words
`define EMB_BOOT_WORDS 2048
`define EMB_BYTE_LAST 2'h2
`endif

// ### emb_pkg.sv
// types shared by the external memory bus interface
// assumes nothing beyond a SystemVerilog compiler
package emb_pkg;
	// one access request from the core
	typedef struct packed {
		logic is_prog; // program space when high
		logic wr; // write when high
		logic [13:0] addr; // word address
		logic [15:0] wdata; // register data
	} emb_req_t;
	// answer to the core
	typedef struct packed {
		logic ack; // one-cycle done pulse
		logic internal; // address is on-chip, core serves it
		logic [23:0] rdata; // whole external word
	} emb_resp_t;
	// software settings
	typedef struct packed {
		logic go; // keep executing while granted
		logic [2:0] page; // boot page
		logic [2:0] boot_ws; // boot wait states
		logic [2:0] pm_ws; // program wait states
		logic [14:0] dm_ws; // three bits per data zone
	} emb_cfg_t;
	// boot word into on-chip program memory
	typedef struct packed {
		logic valid; // one-cycle pulse
		logic [10:0] addr; // word index
		logic [23:0] data; // packed word
	} emb_pmw_t;
	typedef enum logic [2:0] {
		S_START, S_IDLE, S_ACC, S_BOOT, S_GRANT
	} emb_state_t;
endpackage : emb_pkg

// ### emb_regs.sv
// control, wait-state, status and low-byte registers
// assumes one strobe per cycle, read data wanted one cycle later
`include "emb_params.svh"
module emb_regs (
	input wire logic mclk, // clock
	input wire logic rst_n, // synced reset
	input wire logic [13:0] reg_addr, // register address
	input wire logic [15:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [15:0] reg_rdata, // read data, next cycle
	input wire logic lbx_ld, // load low byte from bus
	input wire logic [7:0] lbx_val, // byte from bus
	input wire logic [3:0] status, // live block state
	output emb_pkg::emb_cfg_t cfg, // settings
	output logic force_boot, // one-cycle pulse
	output logic [7:0] prog_low_byte_ext // low-byte extension
);
	wire hit_sc = reg_addr == `EMB_A_SYSCTL;
	wire hit_dw = reg_addr == `EMB_A_DMWAIT;
	wire hit_st = reg_addr == `EMB_A_STATUS;
	wire hit_lbx = reg_addr == `EMB_A_LBX;
	wire [15:0] sc_rd = {5'h0, cfg.go, 1'b0, cfg.page, cfg.boot_ws,
		cfg.pm_ws};
	// unmapped addresses read zero
	wire [15:0] rmux = hit_sc ? sc_rd :
		hit_dw ? {1'b0, cfg.dm_ws} :
		hit_st ? {12'h0, status} :
		hit_lbx ? {8'h0, prog_low_byte_ext} : 16'h0000;
	////////////////////////////////////////////////////////////////////
	// settings; program and data wait counts come up at their slowest, boot wait count at 3
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg.go <= 1'b0;
			cfg.page <= `EMB_PAGE_RST;
			cfg.boot_ws <= `EMB_BOOT_WS_RST;
			cfg.pm_ws <= `EMB_PM_WS_RST;
			cfg.dm_ws <= `EMB_DM_WS_RST;
		end else if (reg_wr && hit_sc) begin
			cfg.go <= reg_wdata[`EMB_SC_GO];
			cfg.page <= reg_wdata[`EMB_SC_PAGE +: 3];
			cfg.boot_ws <= reg_wdata[`EMB_SC_BWS +: 3];
			cfg.pm_ws <= reg_wdata[`EMB_SC_PMWS +: 3];
		end else if (reg_wr && hit_dw) begin
			cfg.dm_ws <= reg_wdata[14:0];
		end
	end
	// force bit is a command, it reads back as zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			force_boot <= 1'b0;
			reg_rdata <= 16'h0000;
			prog_low_byte_ext <= 8'h00;
		end else begin
			force_boot <= reg_wr && hit_sc && reg_wdata[`EMB_SC_FORCE];
			reg_rdata <= reg_rd ? rmux : 16'h0000;
			// a bus read landing with a software write wins
			if (lbx_ld)
				prog_low_byte_ext <= lbx_val;
			else if (reg_wr && hit_lbx)
				prog_low_byte_ext <= reg_wdata[7:0];
		end
	end
endmodule : emb_regs

// ### emb_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs asynchronous to mclk
module emb_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic mclk, // clock
	input wire logic rst_n, // synced reset
	input wire logic [W-1:0] din, // raw pins
	output logic [W-1:0] dout // filtered level
);
	logic [W-1:0] s1_q; // metastability stage, read by s2 only
	logic [W-1:0] s2_q; // second stage
	logic [W-1:0] s3_q; // third stage
	// a change counts only once stages two and three agree
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			dout <= INIT;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			dout <= (s2_q & s3_q) | (dout & (s2_q ^ s3_q));
		end
	end
endmodule : emb_sync

// ### emb_top.sv
// external memory bus interface: program, data and boot memory
// cycles, wait states, boot loader and bus request/grant.
// assumes asynchronous memories and a core that holds its request
// until the acknowledge pulse.
//
// Local design decisions: the strobed register port and the address map.
`include "emb_params.svh"
module emb_top #(
	parameter int BOOT_WORDS = `EMB_BOOT_WORDS
) (
	input wire logic mclk, // processor clock
	input wire logic nrst, // async reset, active low
	input wire logic [13:0] reg_addr, // register address
	input wire logic [15:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [15:0] reg_rdata, // register read data
	input wire logic core_req, // core access pending
	input wire emb_pkg::emb_req_t core_cmd, // core access
	output emb_pkg::emb_resp_t core_resp, // core answer
	output logic halt, // core must stall
	output logic booting, // boot load pending
	output emb_pkg::emb_pmw_t pmw, // boot word write
	output logic [13:0] addr_out, // address pins
	output logic addr_oe, // address drive enable
	input wire logic [23:0] d_in, // data pins in
	output logic [23:0] d_out, // data pins out
	output logic [23:0] d_oe, // data drive enables
	output logic prog_mem_select_n, // program memory select
	output logic data_mem_select_n, // data memory select
	output logic boot_mem_select_n, // boot memory select
	output logic rd_n, // read strobe
	output logic wr_n, // write strobe
	output logic ctl_oe, // select and strobe enable
	input wire logic map_select, // memory map strap
	input wire logic bus_request_in_n, // external request
	output logic bus_grant_out_n // grant to master
);
	////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers
	logic rst1_q; // first reset stage
	logic rst_n; // released reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst1_q <= 1'b1;
			rst_n <= rst1_q;
		end
	end
	logic [1:0] pins_s; // {request_n, map}
	emb_sync #(.W(2), .INIT(2'b10)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.din({bus_request_in_n, map_select}),
		.dout(pins_s)
	);
	wire map_s = pins_s[0];
	wire mreq_act = !pins_s[1];
	////////////////////////////////////////////////////////////////////
	// registers
	emb_pkg::emb_cfg_t cfg; // settings
	logic force_boot; // software boot command
	logic [7:0] prog_low_byte_ext; // low-byte extension
	emb_pkg::emb_state_t st_q; // sequencer state
	logic boot_pend_q; // boot still to do
	logic [2:0] wcnt_q; // wait states left
	wire pm_rd_end = st_q == emb_pkg::S_ACC && wcnt_q == 3'h0
		&& !prog_mem_select_n && !rd_n;
	emb_regs u_regs (
		.mclk(mclk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.lbx_ld(pm_rd_end),
		.lbx_val(d_in[7:0]),
		.status({map_s, halt, boot_pend_q, !bus_grant_out_n}),
		.cfg(cfg),
		.force_boot(force_boot),
		.prog_low_byte_ext(prog_low_byte_ext)
	);
	////////////////////////////////////////////////////////////////////
	// address decode
	// external when outside the on-chip RAM for the strap in force
	function automatic logic ext_of(input logic prog, input logic map,
		input logic [13:0] a);
		if (!prog)
			ext_of = a < `EMB_DM_INT_BASE;
		else if (map)
			ext_of = a < `EMB_PM_HI_BASE;
		else
			ext_of = a >= `EMB_PM_LO_END;
	endfunction : ext_of
	// zone wait count, 2K per zone, the last zone takes the rest
	function automatic logic [2:0] zone_ws(input logic [13:0] a,
		input logic [14:0] ws);
		logic [2:0] z;
		z = (a[13:11] > `EMB_ZONE_LAST) ? `EMB_ZONE_LAST : a[13:11];
		zone_ws = ws[z*3 +: 3];
	endfunction : zone_ws
	wire req_ext = ext_of(core_cmd.is_prog, map_s, core_cmd.addr);
	wire [2:0] req_ws = core_cmd.is_prog ? cfg.pm_ws
		: zone_ws(core_cmd.addr, cfg.dm_ws);
	// the ack cycle still shows the old request, so skip it
	wire req_new = core_req && !core_resp.ack;
	wire idle = st_q == emb_pkg::S_IDLE;
	wire take_core = idle && req_new && !mreq_act && !boot_pend_q;
	wire go_boot = idle && !mreq_act && boot_pend_q;
	wire go_int = st_q == emb_pkg::S_GRANT && cfg.go && req_new
		&& !req_ext;
	wire [15:0] wdata = core_cmd.wdata;
	wire [23:0] wword = core_cmd.is_prog ? {wdata, prog_low_byte_ext}
		: {wdata, 8'h00};
	////////////////////////////////////////////////////////////////////
	// boot counters
	logic [12:0] bbyte_q; // byte within page
	logic [1:0] bphase_q; // byte within word
	logic [10:0] bword_q; // word index
	logic [15:0] bshift_q; // first two bytes of a word
	logic [2:0] start_q; // settle count after reset
	wire byte_done = st_q == emb_pkg::S_BOOT && wcnt_q == 3'h0;
	wire word_done = byte_done && bphase_q == `EMB_BYTE_LAST;
	wire boot_fin = word_done && bword_q == 11'(BOOT_WORDS - 1);
	wire start_end = st_q == emb_pkg::S_START && start_q == `EMB_START_CYC;
	// a boot request in the finishing cycle is kept
	wire boot_pend_d = (start_end && !map_s) || force_boot
		|| (boot_pend_q && !boot_fin);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			boot_pend_q <= 1'b0;
			start_q <= 3'h0;
		end else begin
			boot_pend_q <= boot_pend_d;
			start_q <= start_end ? start_q : start_q + 3'h1;
		end
	end
	// bytes packed first-to-top into 24-bit words
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bbyte_q <= 13'h0000;
			bphase_q <= 2'h0;
			bword_q <= 11'h000;
			bshift_q <= 16'h0000;
			pmw <= '0;
		end else begin
			pmw.valid <= word_done;
			if (byte_done) begin
				bshift_q <= {bshift_q[7:0], d_in[15:8]};
				bbyte_q <= boot_fin ? 13'h0000 : bbyte_q + 13'h0001;
				bphase_q <= word_done ? 2'h0 : bphase_q + 2'h1;
				pmw.addr <= bword_q;
				pmw.data <= {bshift_q, d_in[15:8]};
				if (word_done)
					bword_q <= boot_fin ? 11'h000 : bword_q + 11'h001;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// sequencer; request priority: master, then boot, then core
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= emb_pkg::S_START;
			wcnt_q <= 3'h0;
		end else begin
			unique case (st_q)
				emb_pkg::S_START: begin
					if (start_end)
						st_q <= emb_pkg::S_IDLE;
				end
				emb_pkg::S_IDLE: begin
					if (mreq_act)
						st_q <= emb_pkg::S_GRANT;
					else if (go_boot) begin
						st_q <= emb_pkg::S_BOOT;
						wcnt_q <= cfg.boot_ws;
					end else if (take_core && req_ext) begin
						st_q <= emb_pkg::S_ACC;
						wcnt_q <= req_ws;
					end
				end
				// grant waits for the strobe to end, byte by byte
				emb_pkg::S_ACC, emb_pkg::S_BOOT: begin
					if (wcnt_q == 3'h0)
						st_q <= emb_pkg::S_IDLE;
					else
						wcnt_q <= wcnt_q - 3'h1;
				end
				emb_pkg::S_GRANT: begin
					if (!mreq_act)
						st_q <= emb_pkg::S_IDLE;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////
	// pins: address and selects only change outside a strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			addr_out <= 14'h0000;
			d_out <= 24'h000000;
			d_oe <= 24'h000000;
			{prog_mem_select_n, data_mem_select_n} <= 2'b11;
			{boot_mem_select_n, rd_n, wr_n} <= 3'b111;
			addr_oe <= 1'b1;
			ctl_oe <= 1'b1;
			bus_grant_out_n <= 1'b1;
		end else if (idle && mreq_act) begin
			{addr_oe, ctl_oe, d_oe} <= '0;
			bus_grant_out_n <= 1'b0;
		end else if (st_q == emb_pkg::S_GRANT && !mreq_act) begin
			{addr_oe, ctl_oe} <= 2'b11;
			bus_grant_out_n <= 1'b1;
		end else if (go_boot) begin
			addr_out <= {cfg.page[0], bbyte_q};
			d_out <= {cfg.page[2:1], 22'h000000};
			d_oe <= `EMB_BOOT_OE;
			boot_mem_select_n <= 1'b0;
			rd_n <= 1'b0;
		end else if (take_core && req_ext) begin
			addr_out <= core_cmd.addr;
			prog_mem_select_n <= !core_cmd.is_prog;
			data_mem_select_n <= core_cmd.is_prog;
			rd_n <= core_cmd.wr;
			wr_n <= !core_cmd.wr;
			d_out <= wword;
			d_oe <= !core_cmd.wr ? 24'h000000
				: core_cmd.is_prog ? `EMB_PM_OE : `EMB_DM_OE;
		end else if (wcnt_q == 3'h0 && (st_q == emb_pkg::S_ACC
			|| st_q == emb_pkg::S_BOOT)) begin
			{prog_mem_select_n, data_mem_select_n} <= 2'b11;
			{boot_mem_select_n, rd_n, wr_n} <= 3'b111;
			d_oe <= 24'h000000;
		end
	end
	////////////////////////////////////////////////////////////////////
	// core answer and stall
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			core_resp <= '0;
			halt <= 1'b1;
			booting <= 1'b0;
		end else begin
			core_resp.ack <= (take_core && !req_ext) || go_int
				|| (st_q == emb_pkg::S_ACC && wcnt_q == 3'h0);
			core_resp.internal <= !req_ext;
			core_resp.rdata <= d_in;
			// during a grant, go mode stalls only for an external access or a pending boot
			halt <= st_q == emb_pkg::S_START || boot_pend_d
				|| (mreq_act && (idle || !bus_grant_out_n)
				&& (!cfg.go || (core_req && req_ext)));
			booting <= boot_pend_d;
		end
	end
	////////////////////////////////////////////////////////////////////
	// checks
	wire strobe = !rd_n || !wr_n;
	logic [3:0] len_q; // cycles of the current or last strobe
	logic strobe_q; // strobe one cycle ago
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			len_q <= 4'h0;
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= strobe;
			if (strobe)
				len_q <= strobe_q ? len_q + 4'h1 : 4'h1;
		end
	end
	property p_grant_float;
		@(posedge mclk) disable iff (!rst_n)
		!bus_grant_out_n |-> !addr_oe && !ctl_oe && d_oe == 24'h000000;
	endproperty
	a_grant_float: assert property (p_grant_float)
		else $error("bus driven while granted");
	property p_grant_next;
		@(posedge mclk) disable iff (!rst_n)
		idle && mreq_act |=> !bus_grant_out_n;
	endproperty
	a_grant_next: assert property (p_grant_next)
		else $error("grant late after request");
	property p_release;
		@(posedge mclk) disable iff (!rst_n)
		st_q == emb_pkg::S_GRANT && !mreq_act |=> bus_grant_out_n && ctl_oe;
	endproperty
	a_release: assert property (p_release)
		else $error("grant kept after request dropped");
	property p_one_strobe;
		@(posedge mclk) disable iff (!rst_n)
		strobe |-> (rd_n ^ wr_n) && $onehot({!prog_mem_select_n,
			!data_mem_select_n, !boot_mem_select_n});
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("strobe without a single select");
	property p_addr_hold;
		@(posedge mclk) disable iff (!rst_n)
		strobe && $past(strobe) |-> $stable(addr_out);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address moved under strobe");
	property p_pm_waits;
		@(posedge mclk) disable iff (!rst_n)
		$fell(strobe) && $past(!prog_mem_select_n)
			|-> len_q == {1'b0, cfg.pm_ws} + 4'h1;
	endproperty
	a_pm_waits: assert property (p_pm_waits)
		else $error("program strobe length wrong");
	property p_boot_waits;
		@(posedge mclk) disable iff (!rst_n)
		$fell(strobe) && $past(!boot_mem_select_n)
			|-> len_q == {1'b0, cfg.boot_ws} + 4'h1;
	endproperty
	a_boot_waits: assert property (p_boot_waits)
		else $error("boot strobe length wrong");
	property p_boot_page;
		@(posedge mclk) disable iff (!rst_n)
		!boot_mem_select_n |-> d_out[23:22] == cfg.page[2:1]
			&& addr_out[13] == cfg.page[0] && d_oe == `EMB_BOOT_OE;
	endproperty
	a_boot_page: assert property (p_boot_page)
		else $error("boot page not on the bus");
	property p_dm_write;
		@(posedge mclk) disable iff (!rst_n)
		!data_mem_select_n && !wr_n |-> d_oe == `EMB_DM_OE;
	endproperty
	a_dm_write: assert property (p_dm_write)
		else $error("data write not on upper bits");
	property p_pm_low;
		@(posedge mclk) disable iff (!rst_n)
		!prog_mem_select_n && !wr_n
			|-> d_out[7:0] == $past(prog_low_byte_ext, 1) || $past(strobe);
	endproperty
	a_pm_low: assert property (p_pm_low)
		else $error("program write low byte wrong");
	c_grant: cover property (@(posedge mclk) disable iff (!rst_n)
		$fell(bus_grant_out_n));
	c_boot_word: cover property (@(posedge mclk) disable iff (!rst_n)
		pmw.valid);
	c_pm_read: cover property (@(posedge mclk) disable iff (!rst_n)
		pm_rd_end);
	c_dm_write: cover property (@(posedge mclk) disable iff (!rst_n)
		!data_mem_select_n && !wr_n);
endmodule : emb_top

// ### emb_top_bench.sv
// self-checking bench for the external memory bus interface
// assumes the memory model answers on the shared pins
module emb_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, core_req = 0;
	logic map_select = 0, bus_request_in_n = 1;
	logic [13:0] reg_addr = 14'h0000;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	emb_pkg::emb_req_t core_cmd = '0;
	emb_pkg::emb_resp_t core_resp;
	emb_pkg::emb_pmw_t pmw;
	logic halt, booting, addr_oe, ctl_oe, psel_n, dsel_n, bsel_n, rd_n, wr_n;
	logic bus_grant_out_n;
	logic [13:0] addr_out;
	logic [23:0] d_in, d_out, d_oe, q;
	logic in;
	int n_fail = 0, tests_run = 0, cyc = 0, nw = 0, lat, k, n0;
	logic [2:0] page = 3'h0; // page being booted
	////////////////////////////////////////
	// short boot image keeps the run small
	emb_top #(.BOOT_WORDS(4)) i_emb_top (.mclk(mclk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_req(core_req),
		.core_cmd(core_cmd), .core_resp(core_resp), .halt(halt),
		.booting(booting), .pmw(pmw), .addr_out(addr_out),
		.addr_oe(addr_oe), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
		.prog_mem_select_n(psel_n), .data_mem_select_n(dsel_n),
		.boot_mem_select_n(bsel_n), .rd_n(rd_n), .wr_n(wr_n),
		.ctl_oe(ctl_oe), .map_select(map_select),
		.bus_request_in_n(bus_request_in_n),
		.bus_grant_out_n(bus_grant_out_n));
	emb_mem_model i_emb_mem_model (.mclk(mclk), .addr_out(addr_out),
		.d_out(d_out), .d_oe(d_oe), .prog_mem_select_n(psel_n),
		.data_mem_select_n(dsel_n), .boot_mem_select_n(bsel_n),
		.rd_n(rd_n), .wr_n(wr_n), .ctl_oe(ctl_oe), .d_in(d_in));
	always #2 mclk = ~mclk;
	////////////////////////////////////////
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	// register write, one strobe cycle
	task automatic rw(input logic [13:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 0;
	endtask : rw
	// register read, data stands in the following cycle only
	task automatic rchk(input logic [13:0] a, input logic [15:0] e);
		@(posedge mclk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 0;
		@(posedge mclk);
		chk(reg_rdata, e);
	endtask : rchk
	// core access held until the ack pulse; lat counts edges
	task automatic acc(input logic p, input logic w, input logic [13:0] a,
			input logic [15:0] d);
		lat = 0;
		@(posedge mclk);
		core_req <= 1;
		core_cmd <= {p, w, a, d};
		do begin
			@(posedge mclk);
			lat++;
		end while (core_resp.ack !== 1'b1 && lat < 40);
		q = core_resp.rdata;
		in = core_resp.internal;
		core_req <= 0;
	endtask : acc
	// packed boot word: bytes of page p, first byte on top
	function automatic logic [23:0] exp_word(input logic [2:0] p,
			input int w);
		logic [23:0] r;
		r = '0;
		for (int i = 0; i < 3; i++) r = {r[15:0], {p, 5'(3 * w + i)} ^ 8'h3C};
		return r;
	endfunction : exp_word
	////////////////////////////////////////
	// every boot word is compared as it is written
	always @(posedge mclk) begin
		if (pmw.valid === 1'b1) begin
			chk(pmw.addr, nw[23:0]);
			chk(pmw.data, exp_word(page, nw));
			nw++;
		end
	end
	// hang guard, far above the few hundred cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	////////////////////////////////////////
	initial begin
		repeat (2) @(posedge mclk);
		nrst <= 1;
		repeat (8) @(posedge mclk);
		chk(booting, 1);
		for (k = 0; k < 400 && booting !== 1'b0; k++) @(posedge mclk);
		@(posedge mclk);
		chk(nw[23:0], 4);
		rchk(14'h3FFF, 16'h001F);
		rchk(14'h3FFE, 16'h7FFF);
		rchk(14'h3FF0, 16'h0000);
		// prog waits 2, zone 4 waits 0, low byte 0x56
		rw(14'h3FFF, 16'h001A);
		rw(14'h3FFE, 16'h0FFF);
		rw(14'h3FFC, 16'h0056);
		acc(1, 1, 14'h0805, 16'h1234);
		chk(lat, 5);
		chk(i_emb_mem_model.pm[5], 24'h123456);
		rw(14'h3FFC, 16'h0000);
		acc(1, 0, 14'h0805, 16'h0000);
		chk(q, 24'h123456);
		rchk(14'h3FFC, 16'h0056);
		acc(1, 0, 14'h0010, 16'h0000);
		chk({in, 5'(lat)}, {1'b1, 5'd2});
		acc(0, 1, 14'h2005, 16'hBEEF);
		chk(lat, 3);
		chk(i_emb_mem_model.dm[5], 16'hBEEF);
		acc(0, 1, 14'h0006, 16'hC0DE);
		chk(lat, 10);
		acc(0, 0, 14'h2005, 16'h0000);
		chk(q[23:8], 16'hBEEF);
		acc(0, 0, 14'h3800, 16'h0000);
		chk(in, 1);
		// idle bus request, checked while granted; release follows the go mode checks
		bus_request_in_n <= 0;
		for (k = 0; k < 10 && bus_grant_out_n !== 1'b0; k++) @(posedge mclk);
		chk({addr_oe, ctl_oe, halt}, 3'h1);
		chk(d_oe, 24'h000000);
		rchk(14'h3FFD, 16'h0005);
		// go mode: internal access runs on, external one stalls
		rw(14'h3FFF, 16'h041A);
		acc(0, 0, 14'h3800, 16'h0000);
		chk({in, halt, 5'(lat)}, {2'b10, 5'd2});
		acc(0, 0, 14'h0006, 16'h0000);
		chk({halt, 6'(lat)}, {1'b1, 6'd40});
		bus_request_in_n <= 1;
		for (k = 0; k < 10 && bus_grant_out_n !== 1'b1; k++) @(posedge mclk);
		chk({addr_oe, ctl_oe, bus_grant_out_n}, 3'h7);
		// forced boot of page 5 with a request in mid-load
		page = 3'h5;
		nw = 0;
		rw(14'h3FFF, 16'h035A);
		rchk(14'h3FFF, 16'h015A);
		bus_request_in_n <= 0;
		for (k = 0; k < 30 && bus_grant_out_n !== 1'b0; k++) @(posedge mclk);
		chk({booting, ctl_oe, bus_grant_out_n}, 3'h4);
		n0 = nw;
		repeat (20) @(posedge mclk);
		chk(nw[23:0], n0[23:0]);
		bus_request_in_n <= 1;
		for (k = 0; k < 400 && booting !== 1'b0; k++) @(posedge mclk);
		@(posedge mclk);
		chk(nw[23:0], 4);
		// map strap high: no boot, external program from zero
		nrst <= 0;
		map_select <= 1;
		repeat (2) @(posedge mclk);
		nrst <= 1;
		repeat (12) @(posedge mclk);
		chk({booting, nw[2:0]}, 4'h4);
		acc(1, 0, 14'h0010, 16'h0000);
		chk({in, 5'(lat)}, {1'b0, 5'd10});
		acc(1, 0, 14'h3800, 16'h0000);
		chk(in, 1);
		results();
	end
endmodule : emb_top_bench
